// ===== src/eipf_ctrl.sv
// External pin edge, priority and enable control plus two peripheral flag registers.
// Assumes pins are asynchronous, peripheral strobes are on core_clk.
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps

module eipf_ctrl
  import eipf_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // Avalon-MM slave
  input  wire logic [3:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  // External interrupt pins 0..3
  input  wire logic [3:0]   ext_pin,
  // Port B pull-up control
  input  wire logic [7:0]   portb_latch,
  output logic [7:0]        portb_pullup_en,
  // Peripheral side
  input  eipf_events_t      periph_evt,
  input  wire logic         serial1_rx_full,
  input  wire logic         serial1_tx_empty,
  // Outside enables and flags
  input  wire logic         priority_mode_en,
  input  wire logic         global_high_en,
  input  wire logic         global_low_en,
  input  wire logic         timer0_ovf_src,
  input  wire logic         portb_change_src,
  input  wire logic [7:0]   periph_en_one,
  input  wire logic [7:0]   periph_en_two,
  input  wire logic [7:0]   periph_prio_one,
  input  wire logic [7:0]   periph_prio_two,
  // Status to the rest of the controller
  output logic [3:0]        ext_edge_sel,
  output logic              timer0_ovf_prio,
  output logic              portb_change_prio,
  output logic [2:0]        ext_flag,
  output eipf_irq_t         irq
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0]  edge_prio_q;
  logic [7:0]  ext_ctrl_q;
  logic [7:0]  flags_one_q;
  logic [7:0]  flags_two_q;
  logic [7:0]  edge_prio_d;
  logic [7:0]  ext_ctrl_d;
  logic [7:0]  flags_one_d;
  logic [7:0]  flags_two_d;
  logic        ack_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [3:0]  s1_q;
  logic [3:0]  s2_q;
  logic [3:0]  s3_q;
  logic [3:0]  pin_q;
  logic [7:0]  pullup_q;
  logic [3:0]  edge_out_q;
  logic        t0_prio_q;
  logic        rb_prio_q;
  logic [2:0]  ext_flag_q;
  eipf_irq_t   irq_q;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire         acc       = (avs_read | avs_write) & ~ack_q;
  wire         wr_go     = avs_write & ~ack_q & avs_byteenable[0];
  wire         sel_ep    = (avs_address == ADDR_EDGE_PRIO);
  wire         sel_ec    = (avs_address == ADDR_EXT_CTRL);
  wire         sel_f1    = (avs_address == ADDR_FLAGS_ONE);
  wire         sel_f2    = (avs_address == ADDR_FLAGS_TWO);
  wire [7:0]   wd        = avs_writedata[7:0];
  wire         wr_ep     = wr_go & sel_ep;
  wire         wr_ec     = wr_go & sel_ec;
  wire         wr_f1     = wr_go & sel_f1;
  wire         wr_f2     = wr_go & sel_f2;

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  // Stable level once second and third stages agree
  wire [3:0]   agree     = ~(s2_q ^ s3_q);
  wire [3:0]   pin_d     = (agree & s2_q) | (~agree & pin_q);
  wire [3:0]   rise      = pin_d & ~pin_q;
  wire [3:0]   fall      = ~pin_d & pin_q;
  wire [3:0]   edge_sel  = edge_prio_q[BIT_EDGE_HI:BIT_EDGE_LO];
  // Bit 6 is pin 0, bit 3 is pin 3
  wire [3:0]   sel_pin   = {edge_sel[0], edge_sel[1], edge_sel[2], edge_sel[3]};
  wire [3:0]   pin_evt   = (sel_pin & rise) | (~sel_pin & fall);
  wire [2:0]   ext_evt   = pin_evt[3:1];

  // ------------------------------------------------------------
  // Next register values
  // ------------------------------------------------------------
  wire [2:0]   ext_fl_sw = wr_ec ? wd[2:0] : ext_ctrl_q[2:0];
  wire [2:0]   ext_fl_n  = ext_fl_sw | ext_evt;
  wire [7:0]   f1_evt    = {1'b0, periph_evt.conv_done, 2'b00, periph_evt.sync_serial_done,
                            1'b0, periph_evt.timer2_match, periph_evt.timer1_ovf};
  wire [7:0]   f2_evt    = {periph_evt.osc_fail, periph_evt.comparator_change, 2'b00,
                            periph_evt.bus_collision, periph_evt.low_voltage,
                            periph_evt.timer3_ovf, 1'b0};
  wire [7:0]   f1_sw     = wr_f1 ? wd : flags_one_q;
  wire [7:0]   f2_sw     = wr_f2 ? wd : flags_two_q;
  wire [7:0]   f1_live   = {2'b00, serial1_rx_full, serial1_tx_empty, 4'h0};

  assign edge_prio_d = wr_ep ? wd : edge_prio_q;
  assign ext_ctrl_d  = wr_ec ? {wd[7:3], ext_fl_n} : {ext_ctrl_q[7:3], ext_fl_n};
  assign flags_one_d = (((f1_sw | f1_evt) & SW_FLAGS_ONE) | f1_live) & MASK_FLAGS_ONE;
  assign flags_two_d = (f2_sw | f2_evt) & MASK_FLAGS_TWO;

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  wire [7:0]   rd_byte   = sel_ep ? edge_prio_q :
                           sel_ec ? ext_ctrl_q :
                           sel_f1 ? flags_one_q :
                           sel_f2 ? flags_two_q : 8'h00;

  // ------------------------------------------------------------
  // Request generation
  // ------------------------------------------------------------
  wire [2:0]   ext_en    = ext_ctrl_q[5:3];
  wire [2:0]   ext_prio  = {edge_prio_q[BIT_EXT3_PRIO], ext_ctrl_q[BIT_EXT2_PRIO],
                            ext_ctrl_q[BIT_EXT1_PRIO]};
  wire [2:0]   ext_act   = ext_ctrl_q[2:0] & ext_en;
  wire [7:0]   p1_act    = flags_one_q & periph_en_one;
  wire [7:0]   p2_act    = flags_two_q & periph_en_two;
  wire         hi_any    = |(ext_act & ext_prio) | |(p1_act & periph_prio_one) |
                           |(p2_act & periph_prio_two);
  wire         lo_any    = |(ext_act & ~ext_prio) | |(p1_act & ~periph_prio_one) |
                           |(p2_act & ~periph_prio_two);
  wire         per_any   = |p1_act | |p2_act;
  // Compatibility: high enable is global, low enable gates peripherals
  wire         cmp_req   = global_high_en & (|ext_act | (global_low_en & per_any));
  wire         hi_req    = global_high_en & hi_any;
  wire         lo_req    = global_low_en & lo_any & ~hi_req;
  eipf_irq_t   irq_d;
  assign irq_d.req    = priority_mode_en ? (hi_req | lo_req) : cmp_req;
  assign irq_d.vector = (priority_mode_en & ~hi_req & lo_req) ? VEC_LOW : VEC_HIGH;

  wire [7:0]   pullup_d  = edge_prio_q[BIT_PULLUP_DIS] ? 8'h00 : portb_latch;

  // ------------------------------------------------------------
  // Flip-flops
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      pin_q <= 4'h0;
    end else begin
      s1_q <= ext_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_prio_q <= RST_EDGE_PRIO;
      ext_ctrl_q  <= RST_EXT_CTRL;
      flags_one_q <= 8'h00;
      flags_two_q <= 8'h00;
    end else begin
      edge_prio_q <= edge_prio_d;
      ext_ctrl_q  <= ext_ctrl_d;
      flags_one_q <= flags_one_d;
      flags_two_q <= flags_two_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q   <= 1'b0;
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= acc;
      wait_q  <= ~acc;
      rdata_q <= (avs_read & ~ack_q) ? {24'h000000, rd_byte} : rdata_q;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pullup_q   <= 8'h00;
      edge_out_q <= 4'hf;
      t0_prio_q  <= 1'b1;
      rb_prio_q  <= 1'b1;
      ext_flag_q <= 3'h0;
      irq_q      <= '0;
    end else begin
      pullup_q   <= pullup_d;
      edge_out_q <= sel_pin;
      t0_prio_q  <= edge_prio_q[BIT_TMR0_PRIO];
      rb_prio_q  <= edge_prio_q[BIT_RBCHG_PRIO];
      ext_flag_q <= ext_ctrl_q[2:0];
      irq_q      <= irq_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Waitrequest low only in the acknowledge cycle
  assign avs_waitrequest   = wait_q;
  assign avs_readdata      = rdata_q;
  assign portb_pullup_en   = pullup_q;
  assign ext_edge_sel      = edge_out_q;
  assign timer0_ovf_prio   = t0_prio_q;
  assign portb_change_prio = rb_prio_q;
  assign ext_flag          = ext_flag_q;
  assign irq               = irq_q;

endmodule // eipf_ctrl

// ===== src/eipf_pkg.sv
// Package for the external pin interrupt and peripheral flag controller.
// Assumes one 20 MHz clock and a 32-bit Avalon-MM register port.
package eipf_pkg;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_EDGE_PRIO  = 4'h0;
  localparam logic [3:0] ADDR_EXT_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_FLAGS_ONE  = 4'h8;
  localparam logic [3:0] ADDR_FLAGS_TWO  = 4'hc;
  localparam logic [3:0] ADDR_CORE_CTRL  = 4'h0;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_PULLUP_DIS   = 7;
  localparam int BIT_EDGE_HI      = 6;
  localparam int BIT_EDGE_LO      = 3;
  localparam int BIT_TMR0_PRIO    = 2;
  localparam int BIT_EXT3_PRIO    = 1;
  localparam int BIT_RBCHG_PRIO   = 0;
  localparam int BIT_EXT2_PRIO    = 7;
  localparam int BIT_EXT1_PRIO    = 6;
  localparam int BIT_EN_LO        = 3;
  localparam int BIT_FLAG_LO      = 0;
  // First flag register
  localparam int BIT_CONV_DONE    = 6;
  localparam int BIT_RX_FULL      = 5;
  localparam int BIT_TX_EMPTY     = 4;
  localparam int BIT_SYNC_DONE    = 3;
  localparam int BIT_TMR2_MATCH   = 1;
  localparam int BIT_TMR1_OVF     = 0;
  // Second flag register
  localparam int BIT_OSC_FAIL     = 7;
  localparam int BIT_CMP_CHANGE   = 6;
  localparam int BIT_BUS_COLL     = 3;
  localparam int BIT_LOW_VOLT     = 2;
  localparam int BIT_TMR3_OVF     = 1;

  // ------------------------------------------------------------
  // Reset values and implemented-bit masks
  // ------------------------------------------------------------
  localparam logic [7:0] RST_EDGE_PRIO   = 8'hff;
  localparam logic [7:0] RST_EXT_CTRL    = 8'hc0;
  localparam logic [7:0] MASK_FLAGS_ONE  = 8'h7b;
  localparam logic [7:0] MASK_FLAGS_TWO  = 8'hce;
  localparam logic [7:0] SW_FLAGS_ONE    = 8'h4b;

  // ------------------------------------------------------------
  // Vectors
  // ------------------------------------------------------------
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW  = 16'h0018;

  // Peripheral events, one-cycle pulses
  typedef struct packed {
    logic conv_done;
    logic sync_serial_done;
    logic timer2_match;
    logic timer1_ovf;
    logic osc_fail;
    logic comparator_change;
    logic bus_collision;
    logic low_voltage;
    logic timer3_ovf;
  } eipf_events_t;

  // Interrupt request to the vectoring logic
  typedef struct packed {
    logic        req;
    logic [15:0] vector;
  } eipf_irq_t;

endpackage

// ===== bench/eipf_periph_model.sv
// Peripheral model: bench triggers become one-cycle event pulses.
// Assumes triggers and buffer levels come from the bench on core_clk.
`timescale 1ns/10ps
module eipf_periph_model
  import eipf_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic [8:0] fire,
  input  wire logic       rx_lvl,
  input  wire logic       tx_lvl,
  output eipf_events_t    periph_evt,
  output logic            serial1_rx_full,
  output logic            serial1_tx_empty
);
  logic [8:0] fire_q;
  // Pulse only on a new trigger so the bench may hold it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fire_q <= 9'h000;
      periph_evt <= '0;
      serial1_rx_full <= 1'b0;
      serial1_tx_empty <= 1'b0;
    end else begin
      fire_q <= fire;
      periph_evt <= fire & ~fire_q;
      serial1_rx_full <= rx_lvl;
      serial1_tx_empty <= tx_lvl;
    end
  end
endmodule // eipf_periph_model

// ===== bench/eipf_ctrl_properties.sv
// Port checker for the pin interrupt and flag controller.
// Assumes one clock domain; attached to every instance by bind.
`timescale 1ns/10ps
module eipf_ctrl_chk
  import eipf_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [3:0]  ext_pin,
  input wire logic [7:0]  portb_latch,
  input wire logic [7:0]  portb_pullup_en,
  input wire logic        priority_mode_en,
  input wire logic        global_high_en,
  input wire logic        global_low_en,
  input wire logic [3:0]  ext_edge_sel,
  input wire logic [2:0]  ext_flag,
  input eipf_irq_t        irq
);
  wire  wr_take = avs_write && avs_waitrequest && avs_byteenable[0];
  wire  rd_take = avs_read && avs_waitrequest;
  logic pu_dis_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pu_dis_q <= 1'b1;
    end else if (wr_take && avs_address == ADDR_EDGE_PRIO) begin
      pu_dis_q <= avs_writedata[BIT_PULLUP_DIS];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  AST_PULLUP: assert property (portb_pullup_en ==
    ($past(pu_dis_q) ? 8'h00 : $past(portb_latch))) else $error("pull-up output wrong");
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  AST_ONE_LOW: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_UPPER_ZERO: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_FLAGS_ONE_GAP: assert property (rd_take && avs_address == ADDR_FLAGS_ONE |=>
    (avs_readdata[7:0] & ~MASK_FLAGS_ONE) == 8'h00) else $error("gap bits one set");
  AST_FLAGS_TWO_GAP: assert property (rd_take && avs_address == ADDR_FLAGS_TWO |=>
    (avs_readdata[7:0] & ~MASK_FLAGS_TWO) == 8'h00) else $error("gap bits two set");
  AST_STICKY: assert property (|($past(ext_flag) & ~ext_flag) |->
    $past(wr_take && avs_address == ADDR_EXT_CTRL, 2)) else $error("pin flag fell alone");
  for (genvar i = 1; i < 4; i++) begin : g_pin
    AST_PIN_EDGE: assert property (($rose(ext_pin[i]) && ext_edge_sel[i]) ||
      ($fell(ext_pin[i]) && !ext_edge_sel[i]) |-> ##[1:7] ext_flag[i-1])
      else $error("pin edge not flagged");
  end
  AST_COMPAT_VEC: assert property ($past(!priority_mode_en) && irq.req |->
    irq.vector == VEC_HIGH) else $error("compat vector wrong");
  AST_GLOBAL_OFF: assert property ($past(!global_high_en &&
    (!priority_mode_en || !global_low_en)) |-> !irq.req) else $error("request while off");
  cover property (wr_take && avs_address == ADDR_EXT_CTRL);
  cover property (irq.req && irq.vector == VEC_LOW);
  cover property (ext_flag == 3'h7);
endmodule // eipf_ctrl_chk
bind eipf_ctrl eipf_ctrl_chk u_chk (.*);

// ===== bench/tb_top.sv
// Self-checking bench for the pin interrupt and flag controller.
// Assumes the peripheral model and the bound checker are compiled first.
`timescale 1ns/10ps
module tb_top;
  import eipf_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0, ext_pin = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, seed = 32'd44;
  logic [7:0] portb_latch = 8'h5a, periph_en_one = 8'h00, periph_prio_one = 8'h00;
  logic priority_mode_en = 1'b0, global_high_en = 1'b0, global_low_en = 1'b0;
  logic rx_full = 1'b0, tx_empty = 1'b0, avs_waitrequest, serial1_rx_full;
  logic serial1_tx_empty, timer0_ovf_prio, portb_change_prio;
  logic [8:0] fire = 9'h000;
  logic [7:0] v, w, portb_pullup_en;
  logic [3:0] ext_edge_sel;
  logic [2:0] ext_flag;
  eipf_events_t periph_evt;
  eipf_irq_t irq;
  int failures = 0, checks_done = 0, cycles = 0;
  logic [15:0] evt_map [9] = '{16'h4000, 16'h0800, 16'h0200, 16'h0100, 16'h0080,
                               16'h0040, 16'h0008, 16'h0004, 16'h0002};
  logic [10:0] cfg [6] = '{11'h700, 11'h640, 11'h600, 11'h300, 11'h240, 11'h140};
  logic [16:0] exp_irq [6] = '{{1'b1, VEC_LOW}, {1'b1, VEC_HIGH}, 17'h0,
                               {1'b1, VEC_HIGH}, 17'h0, 17'h0};
  eipf_ctrl DUT (.*, .timer0_ovf_src(1'b0), .portb_change_src(1'b0),
    .periph_en_two(8'h00), .periph_prio_two(8'h00));
  eipf_periph_model u_model (.core_clk, .arst_n, .fire, .rx_lvl(rx_full), .tx_lvl(tx_empty),
    .periph_evt, .serial1_rx_full, .serial1_tx_empty);
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] exp_edge(input logic [7:0] r);
    return {r[3], r[4], r[5], r[6]};
  endfunction
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hf);
    chk(rd, {24'h0, e});
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 5000) begin
      failures++;
      results();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    rdchk(ADDR_EDGE_PRIO, 8'hff);
    rdchk(ADDR_EXT_CTRL, 8'hc0);
    rdchk(ADDR_FLAGS_ONE, 8'h00);
    rdchk(ADDR_FLAGS_TWO, 8'h00);
    rdchk(4'h2, 8'h00);
    chk(portb_pullup_en, 8'h00);
    for (int i = 0; i < 12; i++) begin
      v = xs();
      w = xs();
      portb_latch <= v ^ w;
      wr(ADDR_EDGE_PRIO, v);
      wr(ADDR_EXT_CTRL, w);
      repeat (3) @(posedge core_clk);
      rdchk(ADDR_EDGE_PRIO, v);
      rdchk(ADDR_EXT_CTRL, w);
      chk(ext_edge_sel, exp_edge(v));
      chk({timer0_ovf_prio, portb_change_prio}, {v[2], v[0]});
      chk(portb_pullup_en, v[7] ? 8'h00 : portb_latch);
    end
    bus(1'b1, ADDR_EXT_CTRL, ~w, 4'he);
    rdchk(ADDR_EXT_CTRL, w);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_EDGE_PRIO, p ? 8'h78 : 8'h00);
      ext_pin <= p ? 4'h0 : 4'hf;
      repeat (8) @(posedge core_clk);
      wr(ADDR_EXT_CTRL, 8'hc0);
      ext_pin <= p ? 4'hf : 4'h0;
      repeat (8) @(posedge core_clk);
      rdchk(ADDR_EXT_CTRL, 8'hc7);
      chk(ext_flag, 3'h7);
      wr(ADDR_EXT_CTRL, 8'hc0);
      ext_pin <= p ? 4'h0 : 4'hf;
      repeat (8) @(posedge core_clk);
      rdchk(ADDR_EXT_CTRL, 8'hc0);
    end
    rx_full <= 1'b1;
    for (int j = 0; j < 9; j++) begin
      fire <= 9'h100 >> j;
      repeat (3) @(posedge core_clk);
      fire <= 9'h000;
      rdchk(ADDR_FLAGS_ONE, evt_map[j][15:8] | 8'h20);
      rdchk(ADDR_FLAGS_TWO, evt_map[j][7:0]);
      wr(ADDR_FLAGS_ONE, 8'h00);
      wr(ADDR_FLAGS_TWO, 8'h00);
    end
    rx_full <= 1'b0;
    tx_empty <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdchk(ADDR_FLAGS_ONE, 8'h10);
    fire <= 9'h100;
    wr(ADDR_FLAGS_ONE, 8'h00);
    fire <= 9'h000;
    rdchk(ADDR_FLAGS_ONE, 8'h50);
    periph_en_one <= 8'h40;
    for (int k = 0; k < 6; k++) begin
      {priority_mode_en, global_high_en, global_low_en, periph_prio_one} <= cfg[k];
      repeat (4) @(posedge core_clk);
      chk({irq.req, irq.req ? irq.vector : 16'h0}, exp_irq[k]);
    end
    // Mid-run reset returns registers to their power-on values
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rdchk(ADDR_EDGE_PRIO, 8'hff);
    rdchk(ADDR_EXT_CTRL, 8'hc0);
    chk(irq.req, 1'b0);
    chk(portb_pullup_en, 8'h00);
    results();
  end
endmodule // tb_top
